// ---- src/fmau_pkg.sv ----
// Package with opcodes, carriers and constants of the fractional multiply-accumulate unit.
package fmau_pkg;

	// ----------------------------------------------------------------
	// Widths and counts
	// ----------------------------------------------------------------
	localparam int ACC_COUNT = 4;
	localparam int HALF_HI_LSB = 16;
	localparam int WORD_HI_LSB = 32;

	// ----------------------------------------------------------------
	// Fixed-point limits, rounding constant and reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] Q15_NEG_ONE = 16'h8000;
	localparam logic [15:0] Q15_MAX = 16'h7FFF;
	localparam logic [15:0] HALF_MIN = 16'h8000;
	localparam logic [31:0] Q31_NEG_ONE = 32'h80000000;
	localparam logic [31:0] Q31_MAX = 32'h7FFFFFFF;
	localparam logic [63:0] Q31_MAX_EXT = 64'h000000007FFFFFFF;
	localparam logic [63:0] Q31_MIN_EXT = 64'hFFFFFFFF80000000;
	localparam logic [63:0] Q63_MAX = 64'h7FFFFFFFFFFFFFFF;
	localparam logic [63:0] ACC_MAX = 64'h7FFFFFFFFFFFFFFF;
	localparam logic [63:0] ACC_MIN = 64'h8000000000000000;
	localparam logic [63:0] ROUND_ONE = 64'h0000000080000000;
	localparam logic [63:0] ACC_RESET = 64'h0000000000000000;

	// ----------------------------------------------------------------
	// Operations
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_NONE,
		OP_COMPLEX_STEP_MAC,
		OP_LONG_WORD_FRAC_MAC,
		OP_LONG_WORD_FRAC_WORD_MUL_SUB,
		OP_LEFT_HALF_FRAC_MAC,
		OP_RIGHT_HALF_FRAC_MAC,
		OP_LEFT_HALF_FRAC_MAC_SAT,
		OP_RIGHT_HALF_FRAC_MAC_SAT,
		OP_INT_HALF_PAIR_MUL,
		OP_INT_HALF_PAIR_MUL_SAT,
		OP_FRAC_HALF_PAIR_MUL,
		OP_FRAC_WORD_MUL_TRUNC,
		OP_FRAC_WORD_MUL_ROUND,
		OP_INT_HALF_MUL_SUB_ACC,
		OP_WORD_MUL_ADD,
		OP_UWORD_MUL_ADD,
		OP_WORD_MUL_SUB,
		OP_UWORD_MUL_SUB,
		OP_WORD_MUL_TO_ACC,
		OP_UWORD_MUL_TO_ACC
	} fmau_op_t;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		fmau_op_t op;
		logic [1:0] accumulator_select;
		logic [63:0] first_source_reg;
		logic [63:0] second_source_reg;
	} fmau_req_t;

	typedef struct packed {
		logic gpr_valid;
		logic [63:0] gpr_data;
		logic acc_valid;
		logic [1:0] acc_sel;
		logic [63:0] acc_data;
	} fmau_rsp_t;

endpackage

// ---- src/fmau_unit.sv ----
// Fractional multiply-accumulate datapath with four 64-bit accumulators.
`timescale 1ns/1ps

module fmau_unit
	import fmau_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	input fmau_req_t REQ,
	input wire logic [1:0] ACC_READ_SEL,
	output fmau_rsp_t RSP,
	output logic [63:0] ACC_READ_VALUE
);

	// ----------------------------------------------------------------
	// Arithmetic helpers
	// ----------------------------------------------------------------

	// Q15 by Q15 into Q31, with the one unrepresentable case clamped.
	function automatic logic [31:0] q15_product(input logic [15:0] a, input logic [15:0] b);
		logic signed [31:0] p;
		p = $signed(a) * $signed(b);
		if (a == Q15_NEG_ONE && b == Q15_NEG_ONE)
		begin
			return Q31_MAX;
		end
		return {p[30:0], 1'b0};
	endfunction

	// Q31 by Q31 into Q63, clamped the same way.
	function automatic logic [63:0] q31_product(input logic [31:0] a, input logic [31:0] b);
		logic signed [63:0] p;
		p = $signed(a) * $signed(b);
		if (q31_both_neg_one(a, b))
		begin
			return Q63_MAX;
		end
		return {p[62:0], 1'b0};
	endfunction

	function automatic logic [31:0] int_product(input logic [15:0] a, input logic [15:0] b);
		logic signed [31:0] p;
		p = $signed(a) * $signed(b);
		return p;
	endfunction

	// Sixty-four bit add or subtract that clamps at the accumulator extremes.
	function automatic logic [63:0] sat_acc(input logic [63:0] acc, input logic [63:0] val,
		input logic sub);
		logic [64:0] s;
		if (sub)
		begin
			s = {acc[63], acc} - {val[63], val};
		end
		else
		begin
			s = {acc[63], acc} + {val[63], val};
		end
		if (s[64] != s[63])
		begin
			return s[64] ? ACC_MIN : ACC_MAX;
		end
		return s[63:0];
	endfunction

	// Clamp a wide sum into the Q31 range, sign-extended to 64 bits.
	function automatic logic [63:0] sat_q31(input logic [64:0] s);
		if (s[64:31] != '0 && s[64:31] != '1)
		begin
			return s[64] ? Q31_MIN_EXT : Q31_MAX_EXT;
		end
		return s[63:0];
	endfunction

	// Keep the low halfword of a lane product, clamping it when asked.
	function automatic logic [15:0] half_lane(input logic [31:0] p, input logic sat);
		if (sat && p[31:15] != '0 && p[31:15] != '1)
		begin
			return p[31] ? HALF_MIN : Q15_MAX;
		end
		return p[15:0];
	endfunction

	function automatic logic [63:0] sext32(input logic [31:0] w);
		return {{WORD_HI_LSB{w[31]}}, w};
	endfunction

	// Two words at -1.0 give the one Q31 square that has no Q63 representation.
	function automatic logic q31_both_neg_one(input logic [31:0] a, input logic [31:0] b);
		return a == Q31_NEG_ONE && b == Q31_NEG_ONE;
	endfunction

	function automatic logic takes_left_lane(input fmau_op_t op);
		return op == OP_LEFT_HALF_FRAC_MAC || op == OP_LEFT_HALF_FRAC_MAC_SAT;
	endfunction

	function automatic logic pair_saturates(input fmau_op_t op);
		return op == OP_INT_HALF_PAIR_MUL_SAT;
	endfunction

	// ----------------------------------------------------------------
	// Operand split
	// ----------------------------------------------------------------
	logic [31:0] a_word;
	logic [31:0] b_word;
	logic [15:0] a_hi;
	logic [15:0] a_lo;
	logic [15:0] b_hi;
	logic [15:0] b_lo;
	logic [63:0] acc [ACC_COUNT];
	logic [63:0] acc_cur;

	assign a_word = REQ.first_source_reg[31:0];
	assign b_word = REQ.second_source_reg[31:0];
	assign a_hi = a_word[31:HALF_HI_LSB];
	assign a_lo = a_word[HALF_HI_LSB-1:0];
	assign b_hi = b_word[31:HALF_HI_LSB];
	assign b_lo = b_word[HALF_HI_LSB-1:0];
	assign acc_cur = acc[REQ.accumulator_select];

	// ----------------------------------------------------------------
	// Lane products shared by several operations
	// ----------------------------------------------------------------
	logic [31:0] frac_hi;
	logic [31:0] frac_lo;
	logic [31:0] int_hi;
	logic [31:0] int_lo;
	logic [63:0] frac_long;
	logic [63:0] signed_word;
	logic [63:0] unsigned_word;

	assign frac_hi = q15_product(a_hi, b_hi);
	assign frac_lo = q15_product(a_lo, b_lo);
	assign int_hi = int_product(a_hi, b_hi);
	assign int_lo = int_product(a_lo, b_lo);
	assign frac_long = q31_product(a_word, b_word);
	assign signed_word = $signed(a_word) * $signed(b_word);
	assign unsigned_word = {32'h00000000, a_word} * {32'h00000000, b_word};

	// ----------------------------------------------------------------
	// Result selection
	// ----------------------------------------------------------------
	logic next_gpr_valid;
	logic [63:0] next_gpr;
	logic next_acc_valid;
	logic [63:0] next_acc;

	always_comb
	begin
		logic [32:0] diff;
		logic [31:0] sel_frac;
		logic [63:0] rounded;
		diff = '0;
		sel_frac = '0;
		rounded = '0;
		next_gpr_valid = 1'b0;
		next_gpr = '0;
		next_acc_valid = 1'b0;
		next_acc = acc_cur;
		if (REQ.valid)
		begin
			case (REQ.op)
				OP_COMPLEX_STEP_MAC:
				begin
					// The difference of two clamped products needs 33 bits; it is not saturated.
					diff = {frac_hi[31], frac_hi} - {frac_lo[31], frac_lo};
					next_acc = acc_cur + {{31{diff[32]}}, diff};
					next_acc_valid = 1'b1;
				end
				OP_LONG_WORD_FRAC_MAC:
				begin
					next_acc = sat_acc(acc_cur, frac_long, 1'b0);
					next_acc_valid = 1'b1;
				end
				OP_LONG_WORD_FRAC_WORD_MUL_SUB:
				begin
					next_acc = sat_acc(acc_cur, frac_long, 1'b1);
					next_acc_valid = 1'b1;
				end
				OP_LEFT_HALF_FRAC_MAC, OP_RIGHT_HALF_FRAC_MAC:
				begin
					sel_frac = takes_left_lane(REQ.op) ? frac_hi : frac_lo;
					next_acc = acc_cur + sext32(sel_frac);
					next_acc_valid = 1'b1;
				end
				OP_LEFT_HALF_FRAC_MAC_SAT, OP_RIGHT_HALF_FRAC_MAC_SAT:
				begin
					sel_frac = takes_left_lane(REQ.op) ? frac_hi : frac_lo;
					next_acc = sat_q31({acc_cur[63], acc_cur} + {{33{sel_frac[31]}}, sel_frac});
					next_acc_valid = 1'b1;
				end
				OP_INT_HALF_PAIR_MUL, OP_INT_HALF_PAIR_MUL_SAT:
				begin
					sel_frac = {half_lane(int_hi, pair_saturates(REQ.op)),
						half_lane(int_lo, pair_saturates(REQ.op))};
					next_gpr = sext32(sel_frac);
					next_gpr_valid = 1'b1;
				end
				OP_FRAC_HALF_PAIR_MUL:
				begin
					sel_frac = {frac_hi[31:HALF_HI_LSB], frac_lo[31:HALF_HI_LSB]};
					next_gpr = sext32(sel_frac);
					next_gpr_valid = 1'b1;
				end
				OP_FRAC_WORD_MUL_TRUNC:
				begin
					next_gpr = sext32(frac_long[63:WORD_HI_LSB]);
					next_gpr_valid = 1'b1;
				end
				OP_FRAC_WORD_MUL_ROUND:
				begin
					if (q31_both_neg_one(a_word, b_word))
					begin
						next_gpr = Q31_MAX_EXT;
					end
					else
					begin
						rounded = frac_long + ROUND_ONE;
						next_gpr = sext32(rounded[63:WORD_HI_LSB]);
					end
					next_gpr_valid = 1'b1;
				end
				OP_INT_HALF_MUL_SUB_ACC:
				begin
					diff = {int_hi[31], int_hi} - {int_lo[31], int_lo};
					next_acc = acc_cur + {{31{diff[32]}}, diff};
					next_acc_valid = 1'b1;
				end
				OP_WORD_MUL_ADD:
				begin
					next_acc = acc_cur + signed_word;
					next_acc_valid = 1'b1;
				end
				OP_UWORD_MUL_ADD:
				begin
					next_acc = acc_cur + unsigned_word;
					next_acc_valid = 1'b1;
				end
				OP_WORD_MUL_SUB:
				begin
					next_acc = acc_cur - signed_word;
					next_acc_valid = 1'b1;
				end
				OP_UWORD_MUL_SUB:
				begin
					next_acc = acc_cur - unsigned_word;
					next_acc_valid = 1'b1;
				end
				OP_WORD_MUL_TO_ACC:
				begin
					next_acc = signed_word;
					next_acc_valid = 1'b1;
				end
				OP_UWORD_MUL_TO_ACC:
				begin
					next_acc = unsigned_word;
					next_acc_valid = 1'b1;
				end
				default:
				begin
					next_acc = acc_cur;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Accumulator bank
	// ----------------------------------------------------------------

	// Updating at the same edge as the answer lets a following operation use the new value at once.
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			for (int i = 0; i < ACC_COUNT; i++)
			begin
				acc[i] <= ACC_RESET;
			end
		end
		else if (next_acc_valid)
		begin
			acc[REQ.accumulator_select] <= next_acc;
		end
	end

	// ----------------------------------------------------------------
	// Registered answers
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			RSP <= '0;
		end
		else
		begin
			RSP.gpr_valid <= next_gpr_valid;
			RSP.gpr_data <= next_gpr;
			RSP.acc_valid <= next_acc_valid;
			RSP.acc_sel <= REQ.accumulator_select;
			RSP.acc_data <= next_acc;
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			ACC_READ_VALUE <= ACC_RESET;
		end
		else
		begin
			ACC_READ_VALUE <= acc[ACC_READ_SEL];
		end
	end

endmodule // fmau_unit

// ---- verification/fmau_unit_monitor.sv ----
// Port checker of the fractional multiply-accumulate unit.
`timescale 1ns/1ps

module fmau_unit_monitor
	import fmau_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	input fmau_req_t REQ,
	input wire logic [1:0] ACC_READ_SEL,
	input fmau_rsp_t RSP,
	input wire logic [63:0] ACC_READ_VALUE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	logic gpr_code;
	logic gpr_op;
	logic acc_op;
	logic neg_pair;
	logic [63:0] prod;
	assign gpr_code = REQ.op inside {OP_INT_HALF_PAIR_MUL, OP_INT_HALF_PAIR_MUL_SAT, OP_FRAC_HALF_PAIR_MUL,
		OP_FRAC_WORD_MUL_TRUNC, OP_FRAC_WORD_MUL_ROUND};
	assign gpr_op = REQ.valid && gpr_code;
	assign acc_op = REQ.valid && !gpr_code && REQ.op inside {[OP_COMPLEX_STEP_MAC:OP_UWORD_MUL_TO_ACC]};
	assign neg_pair = REQ.first_source_reg[31:0] == Q31_NEG_ONE && REQ.second_source_reg[31:0] == Q31_NEG_ONE;
	assign prod = $signed(REQ.first_source_reg[31:0]) * $signed(REQ.second_source_reg[31:0]);

	gpr_pulse_a: assert property (gpr_op |=> RSP.gpr_valid && !RSP.acc_valid)
		else $error("general result missing");
	acc_pulse_a: assert property (acc_op |=> RSP.acc_valid && RSP.acc_sel == $past(REQ.accumulator_select))
		else $error("accumulator write missing");
	idle_quiet_a: assert property (!REQ.valid |=> !RSP.gpr_valid && !RSP.acc_valid)
		else $error("result without request");
	trunc_clamp_a: assert property (REQ.valid && REQ.op == OP_FRAC_WORD_MUL_TRUNC && neg_pair
		|=> RSP.gpr_data == Q31_MAX_EXT)
		else $error("truncating clamp wrong");
	round_clamp_a: assert property (REQ.valid && REQ.op == OP_FRAC_WORD_MUL_ROUND && neg_pair
		|=> RSP.gpr_data == Q31_MAX_EXT)
		else $error("rounding clamp wrong");
	gpr_sext_a: assert property (RSP.gpr_valid |-> RSP.gpr_data[63:32] == {32{RSP.gpr_data[31]}})
		else $error("upper word not sign copy");
	half_sat_a: assert property (REQ.valid
		&& REQ.op inside {OP_LEFT_HALF_FRAC_MAC_SAT, OP_RIGHT_HALF_FRAC_MAC_SAT}
		|=> $signed(RSP.acc_data) <= $signed(Q31_MAX_EXT) && $signed(RSP.acc_data) >= $signed(Q31_MIN_EXT))
		else $error("saturated sum out of range");
	to_acc_a: assert property (REQ.valid && REQ.op == OP_WORD_MUL_TO_ACC |=> RSP.acc_data == $past(prod))
		else $error("product to accumulator wrong");
	read_track_a: assert property (RSP.acc_valid && ACC_READ_SEL == RSP.acc_sel
		|=> ACC_READ_VALUE == $past(RSP.acc_data))
		else $error("readback lags write");

	cover property (REQ.valid && REQ.op == OP_COMPLEX_STEP_MAC && neg_pair);
	cover property (REQ.valid && REQ.op == OP_LONG_WORD_FRAC_WORD_MUL_SUB ##1 RSP.acc_data == ACC_MIN);
	cover property (REQ.valid && REQ.op == OP_FRAC_WORD_MUL_ROUND && neg_pair);
endmodule // fmau_unit_monitor

bind fmau_unit fmau_unit_monitor u_monitor (.CLOCK(CLOCK), .RST(RST), .REQ(REQ), .ACC_READ_SEL(ACC_READ_SEL),
	.RSP(RSP), .ACC_READ_VALUE(ACC_READ_VALUE));

// ---- verification/fmau_core_model.sv ----
// Core-side model that presents requests to the unit one cycle after they are issued.
`timescale 1ns/1ps

module fmau_core_model
	import fmau_pkg::*;
(
	input wire logic CLOCK,
	input fmau_req_t ISSUE,
	output fmau_req_t REQ
);
	fmau_req_t taken;
	initial REQ = '0;
	// Idle cycles carry inverted operands, so stale fields can never look like a fresh request.
	// The issue is captured at the edge itself, so the bench driving it just after an edge never races this model.
	always @(posedge CLOCK)
	begin
		taken = ISSUE;
		#1;
		REQ = taken.valid ? taken : {1'b0, ~taken[134:0]};
	end
endmodule // fmau_core_model

// ---- verification/fmau_unit_tb.sv ----
// Self-checking testbench of the fractional multiply-accumulate unit.
`timescale 1ns/1ps

module fmau_unit_tb;
	import fmau_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	fmau_req_t issue = '0;
	fmau_req_t req;
	fmau_rsp_t rsp;
	logic [1:0] read_sel = 2'h0;
	logic [63:0] read_value;
	logic [63:0] acc [4];
	logic [31:0] lfsr = 32'h54A0;
	int n_mismatch = 0;
	int n_checks = 0;
	int cycles = 0;

	always #5 clock = ~clock;

	fmau_core_model core (.CLOCK(clock), .ISSUE(issue), .REQ(req));
	fmau_unit DUT (.CLOCK(clock), .RST(rst), .REQ(req), .ACC_READ_SEL(read_sel), .RSP(rsp), .ACC_READ_VALUE(read_value));

	function automatic logic [31:0] next_rand();
		lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h0);
		return lfsr;
	endfunction

	function automatic logic [31:0] pick();
		logic [31:0] r;
		r = next_rand();
		case (r[2:0])
			3'h0: return 32'h80000000;
			3'h1: return 32'h80008000;
			3'h2: return 32'h7FFFFFFF;
			default: return next_rand();
		endcase
	endfunction

	function automatic logic [63:0] q15(logic [15:0] x, logic [15:0] y);
		logic signed [31:0] p;
		p = $signed(x) * $signed(y);
		p = p <<< 1;
		if (x == 16'h8000 && y == 16'h8000)
			p = 32'h7FFFFFFF;
		return {{32{p[31]}}, p};
	endfunction

	function automatic logic [15:0] lane(logic signed [63:0] v, logic sat);
		if (sat && v > 64'sh7FFF)
			return 16'h7FFF;
		if (sat && v < -64'sh8000)
			return 16'h8000;
		return v[15:0];
	endfunction

	function automatic logic [63:0] expect_val(fmau_op_t op, logic [63:0] acc, logic [31:0] a, logic [31:0] b);
		logic signed [64:0] s, m;
		logic signed [63:0] p, l, r, q, h, t;
		logic [63:0] u, hl, hr;
		logic [31:0] g;
		p = $signed(a) * $signed(b);
		u = {32'h0, a} * {32'h0, b};
		l = $signed(a[31:16]) * $signed(b[31:16]);
		r = $signed(a[15:0]) * $signed(b[15:0]);
		q = (a == 32'h80000000 && b == 32'h80000000) ? Q63_MAX : p <<< 1;
		hl = q15(a[31:16], b[31:16]);
		hr = q15(a[15:0], b[15:0]);
		h = op inside {OP_LEFT_HALF_FRAC_MAC, OP_LEFT_HALF_FRAC_MAC_SAT} ? hl : hr;
		t = acc + h;
		m = $signed({acc[63], acc}) + h;
		s = op == OP_LONG_WORD_FRAC_MAC ? $signed({acc[63], acc}) + q : $signed({acc[63], acc}) - q;
		case (op)
			OP_COMPLEX_STEP_MAC: return acc + hl - hr;
			OP_LONG_WORD_FRAC_MAC, OP_LONG_WORD_FRAC_WORD_MUL_SUB: return s[64] != s[63] ? (s[64] ? ACC_MIN : ACC_MAX) : s[63:0];
			OP_LEFT_HALF_FRAC_MAC, OP_RIGHT_HALF_FRAC_MAC: return t;
			OP_LEFT_HALF_FRAC_MAC_SAT, OP_RIGHT_HALF_FRAC_MAC_SAT:
				return m > $signed(Q31_MAX_EXT) ? Q31_MAX_EXT : (m < $signed(Q31_MIN_EXT) ? Q31_MIN_EXT : m[63:0]);
			OP_INT_HALF_PAIR_MUL, OP_INT_HALF_PAIR_MUL_SAT:
				g = {lane(l, op == OP_INT_HALF_PAIR_MUL_SAT), lane(r, op == OP_INT_HALF_PAIR_MUL_SAT)};
			OP_FRAC_HALF_PAIR_MUL: g = {hl[31:16], hr[31:16]};
			OP_FRAC_WORD_MUL_TRUNC: g = q[63:32];
			OP_FRAC_WORD_MUL_ROUND: g = q == Q63_MAX ? Q31_MAX : 32'((q + ROUND_ONE) >>> 32);
			OP_INT_HALF_MUL_SUB_ACC: return acc + l - r;
			OP_WORD_MUL_ADD: return acc + p;
			OP_UWORD_MUL_ADD: return acc + u;
			OP_WORD_MUL_SUB: return acc - p;
			OP_UWORD_MUL_SUB: return acc - u;
			OP_WORD_MUL_TO_ACC: return p;
			OP_UWORD_MUL_TO_ACC: return u;
			default: return acc;
		endcase
		return {{32{g[31]}}, g};
	endfunction

	task check_flag(string n, logic e, logic g);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task check_word(string n, logic [63:0] e, logic [63:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task run_op(fmau_op_t op, logic [1:0] sel, logic [31:0] a, logic [31:0] b);
		logic [63:0] e;
		logic g;
		logic w;
		g = op inside {OP_INT_HALF_PAIR_MUL, OP_INT_HALF_PAIR_MUL_SAT, OP_FRAC_HALF_PAIR_MUL,
			OP_FRAC_WORD_MUL_TRUNC, OP_FRAC_WORD_MUL_ROUND};
		w = !g && op inside {[OP_COMPLEX_STEP_MAC:OP_UWORD_MUL_TO_ACC]};
		e = expect_val(op, acc[sel], a, b);
		@(posedge clock);
		#1;
		issue = '{1'b1, op, sel, {~a, a}, {b, b}};
		read_sel = sel;
		@(posedge clock);
		#1;
		issue.valid = 1'b0;
		@(posedge clock);
		#1;
		check_flag("gpr_valid", g, rsp.gpr_valid);
		check_flag("acc_valid", w, rsp.acc_valid);
		if (g)
			check_word("gpr_data", e, rsp.gpr_data);
		if (w)
			check_word("acc_data", e, rsp.acc_data);
		if (w)
			check_word("acc_sel", 64'(sel), 64'(rsp.acc_sel));
		if (w)
			acc[sel] = e;
		@(posedge clock);
		#1;
		check_word("read_value", acc[sel], read_value);
	endtask

	task reset_unit();
		rst = 1'b1;
		foreach (acc[k])
			acc[k] = '0;
		repeat (12) @(posedge clock);
		#1;
		rst = 1'b0;
		check_word("read_value", ACC_RESET, read_value);
	endtask

	task complete_run();
		if (n_mismatch == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		reset_unit();
		for (int i = 1; i < 20; i++)
		begin
			run_op(fmau_op_t'(i), 2'(i), 32'h80008000, 32'h80008000);
			run_op(fmau_op_t'(i), 2'(i + 1), 32'h7FFF8001, 32'h80007FFF);
		end
		repeat (3) run_op(OP_LONG_WORD_FRAC_MAC, 2'h3, 32'h80000000, 32'h80000000);
		run_op(OP_RIGHT_HALF_FRAC_MAC_SAT, 2'h3, 32'h80008000, 32'h80008000);
		repeat (5) run_op(OP_LONG_WORD_FRAC_WORD_MUL_SUB, 2'h3, 32'h80000000, 32'h80000000);
		run_op(OP_LEFT_HALF_FRAC_MAC_SAT, 2'h3, 32'h80008000, 32'h80008000);
		run_op(OP_FRAC_WORD_MUL_TRUNC, 2'h0, 32'h80000000, 32'h80000000);
		run_op(OP_FRAC_WORD_MUL_ROUND, 2'h0, 32'h80000000, 32'h80000000);
		run_op(OP_NONE, 2'h1, 32'h12345678, 32'h9ABCDEF0);
		run_op(fmau_op_t'(5'h1F), 2'h2, 32'h12345678, 32'h9ABCDEF0);
		repeat (400) run_op(fmau_op_t'(5'(next_rand() % 19 + 1)), 2'(next_rand()), pick(), pick());
		reset_unit();
		repeat (40) run_op(fmau_op_t'(5'(next_rand() % 19 + 1)), 2'(next_rand()), pick(), pick());
		complete_run();
	end

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			n_mismatch++;
			complete_run();
		end
	end
endmodule // fmau_unit_tb
